/* ctlp_pkg.sv */
// Constants, field layouts and types for the calibration trigger and
// low-power background calibration controller.
// Assumes a 32-bit AXI4-Lite register bus with word-aligned registers.

package ctlp_pkg;

    // ------------------------------------------------------------------
    // Register indices (byte address is four times the index)
    // ------------------------------------------------------------------
    localparam int          ADDR_W           = 12;
    localparam logic [9:0]  IDX_PIN_CONFIG   = 10'h06B;
    localparam logic [9:0]  IDX_SOFT_TRIGGER = 10'h06C;
    localparam logic [9:0]  IDX_LP_CONTROL   = 10'h06E;
    localparam logic [9:0]  IDX_CAL_CONTROL  = 10'h070;
    localparam logic [9:0]  IDX_CAL_STATUS   = 10'h071;
    localparam logic [9:0]  IDX_IRQ_STATUS   = 10'h072;
    localparam logic [9:0]  IDX_IRQ_CLEAR    = 10'h073;
    localparam logic [9:0]  IDX_IRQ_ENABLE   = 10'h074;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [7:0]  RST_PIN_CONFIG   = 8'h00;
    localparam logic [7:0]  RST_SOFT_TRIGGER = 8'h01;
    localparam logic [7:0]  RST_LP_CONTROL   = 8'h88;
    localparam logic [7:0]  RST_CAL_CONTROL  = 8'h00;
    localparam logic [3:0]  RST_IRQ_ENABLE   = 4'h0;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int          TRIG_SRC_BIT     = 0;
    localparam int          STAT_SEL_LSB     = 1;
    localparam int          STAT_SEL_MSB     = 2;
    localparam int          SOFT_LEVEL_BIT   = 0;
    localparam int          LOW_POWER_CAL_ENABLE_BIT        = 0;
    localparam int          TRIGGERED_SLEEP_MODE_BIT      = 1;
    localparam int          SETTLE_LSB       = 3;
    localparam int          SETTLE_MSB       = 4;
    localparam int          SLEEP_LSB        = 5;
    localparam int          SLEEP_MSB        = 7;
    localparam int          BG_EN_BIT        = 0;
    localparam int          IRQ_W            = 4;

    // ------------------------------------------------------------------
    // Status pin select codes and bus responses
    // ------------------------------------------------------------------
    localparam logic [1:0]  SEL_FOREGROUND_DONE_FLAG      = 2'h0;
    localparam logic [1:0]  SEL_BG_HALTED    = 2'h1;
    localparam logic [1:0]  SEL_ALARM        = 2'h2;
    localparam logic [1:0]  RESP_OKAY        = 2'h0;
    localparam logic [1:0]  RESP_SLVERR      = 2'h2;

    // Interval counts in sample clock periods; 1.1e12 needs 41 bits
    localparam int          CNT_W            = 41;

    typedef struct packed {
        logic alarm;
        logic bg_halted;
        logic foreground_done_flag;
    } ctlp_flags_type;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_SLEEP,
        ST_SETTLE,
        ST_CAL
    } ctlp_state_type;

endpackage

/* ctlp_interval_timer.sv */
// Down-counting interval timer for sleep and settle intervals.
// Assumes one load pulse per interval; a new load restarts the count.

`timescale 1ns/1ps

module ctlp_interval_timer
#(
    parameter int W = 41
)
(
    input  wire logic         i_clk,
    input  wire logic         i_rst_n,
    input  wire logic         i_load,
    input  wire logic [W-1:0] i_count,
    output logic              o_done
);

    logic [W-1:0] cnt_reg;
    logic         done_reg;

    // ------------------------------------------------------------------
    // Counter
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            cnt_reg <= '0;
        else if (i_load)
            cnt_reg <= i_count;
        else if (cnt_reg != '0)
            cnt_reg <= cnt_reg - W'(1);
    end

    // Done flags the last period; a load hides a stale end
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            done_reg <= 1'b0;
        else
            done_reg <= !i_load && (cnt_reg == W'(1));
    end

    assign o_done = done_reg;

endmodule // ctlp_interval_timer

/* ctlp_cal_ctrl.sv */
// Calibration trigger selection, status pin routing and low-power
// background calibration sequencing, with an AXI4-Lite register slave.
// Assumes flags and core handshake come from the calibration engine,
// synchronous to i_clk; the trigger pin is asynchronous.
//
// Overview of operation
// [R1] Select code routes chosen flag to status pin
// [R2] Select 0: software bit drives trigger
// [R3] Select 1: external pin drives trigger
// [R4] Software bit mimics pin level, resets high
// [R5] Unused trigger: select 0, software bit 1
// [R6] Reserved bits written only with zero
// [R7] Sleep code sets autonomous sleep interval length
// [R8] Sleep codes below four not advised
// [R9] Settle code sets wait before calibration
// [R10] Settle code zero not advised
// [R11] Mode 0: timed autonomous sleep
// [R12] Mode 1: sleep while trigger high
// [R13] Low-power enable needs background enable, resets 0
// [R14] Foreground done flag shown when complete
// [R15] Halted flag follows background stop and resume
// [R16] Background enable gates all low-power activity
// [R17] Pin synchronised; sleep code 7 acts as 6

`timescale 1ns/1ps

module ctlp_cal_ctrl
    import ctlp_pkg::*;
#(
    parameter logic [40:0] SLEEP_CNT_0  = 41'd1152,
    parameter logic [40:0] SLEEP_CNT_1  = 41'd4194432,
    parameter logic [40:0] SLEEP_CNT_2  = 41'd33554560,
    parameter logic [40:0] SLEEP_CNT_3  = 41'd268435584,
    parameter logic [40:0] SLEEP_CNT_4  = 41'd2147483776,
    parameter logic [40:0] SLEEP_CNT_5  = 41'd17179869312,
    parameter logic [40:0] SLEEP_CNT_6  = 41'd1099511627904,
    parameter logic [40:0] SETTLE_CNT_0 = 41'd1152,
    parameter logic [40:0] SETTLE_CNT_1 = 41'd33554560,
    parameter logic [40:0] SETTLE_CNT_2 = 41'd268435584,
    parameter logic [40:0] SETTLE_CNT_3 = 41'd2147483776
)
(
    input  wire logic                     i_clk,
    input  wire logic                     i_rst_n,
    // AXI4-Lite slave
    input  wire logic [ctlp_pkg::ADDR_W-1:0] i_awaddr,
    input  wire logic                     i_awvalid,
    output logic                          o_awready,
    input  wire logic [31:0]              i_wdata,
    input  wire logic [3:0]               i_wstrb,
    input  wire logic                     i_wvalid,
    output logic                          o_wready,
    output logic [1:0]                    o_bresp,
    output logic                          o_bvalid,
    input  wire logic                     i_bready,
    input  wire logic [ctlp_pkg::ADDR_W-1:0] i_araddr,
    input  wire logic                     i_arvalid,
    output logic                          o_arready,
    output logic [31:0]                   o_rdata,
    output logic [1:0]                    o_rresp,
    output logic                          o_rvalid,
    input  wire logic                     i_rready,
    // Pins and calibration engine
    input  wire logic                     i_external_trigger_pin,
    input  wire ctlp_pkg::ctlp_flags_type i_flags,
    input  wire logic                     i_core_cal_done,
    output logic                          o_cal_status_pin,
    output logic                          o_cal_trigger,
    output logic                          o_core_sleep,
    output logic                          o_cal_start,
    output logic                          o_irq
);

    import ctlp_pkg::*;

    // ------------------------------------------------------------------
    // Declarations
    // ------------------------------------------------------------------
    logic [7:0]       pin_config_reg;
    logic [7:0]       soft_trigger_reg;
    logic [7:0]       lp_control_reg;
    logic [7:0]       cal_control_reg;
    logic [IRQ_W-1:0] irq_status_reg;
    logic [IRQ_W-1:0] irq_enable_reg;
    logic [IRQ_W-1:0] irq_clear;
    logic [IRQ_W-1:0] irq_event;
    logic             trig_meta_reg;
    logic             trig_sync_reg;
    logic             trig_sel;
    ctlp_flags_type   flags_prev_reg;
    ctlp_state_type   state_reg;
    logic             tmr_load_reg;
    logic [CNT_W-1:0] tmr_count_reg;
    logic             tmr_done;
    logic             lp_active;
    logic             trig_mode;
    logic [ADDR_W-1:0] aw_addr_reg;
    logic [31:0]      w_data_reg;
    logic [3:0]       w_strb_reg;
    logic             aw_got_reg;
    logic             w_got_reg;
    logic             do_write;
    logic [31:0]      rd_value;
    logic [1:0]       rd_resp;

    // ------------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------------
    function automatic logic hit(input logic [ADDR_W-1:0] addr,
                                 input logic [9:0]        idx);
        return addr[ADDR_W-1:2] == idx;
    endfunction

    function automatic logic [CNT_W-1:0] sleep_count(input logic [2:0] c);
        case (c)
            3'h0:    return SLEEP_CNT_0;
            3'h1:    return SLEEP_CNT_1;
            3'h2:    return SLEEP_CNT_2;
            3'h3:    return SLEEP_CNT_3;
            3'h4:    return SLEEP_CNT_4;
            3'h5:    return SLEEP_CNT_5;
            default: return SLEEP_CNT_6; // [R17]
        endcase
    endfunction

    function automatic logic [CNT_W-1:0] settle_count(input logic [1:0] c);
        case (c)
            2'h0:    return SETTLE_CNT_0;
            2'h1:    return SETTLE_CNT_1;
            2'h2:    return SETTLE_CNT_2;
            default: return SETTLE_CNT_3;
        endcase
    endfunction

    // ------------------------------------------------------------------
    // Write channel
    // ------------------------------------------------------------------
    assign do_write = aw_got_reg && w_got_reg && !o_bvalid;

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_awready   <= 1'b1;
            o_wready    <= 1'b1;
            aw_got_reg  <= 1'b0;
            w_got_reg   <= 1'b0;
            aw_addr_reg <= '0;
            w_data_reg  <= '0;
            w_strb_reg  <= '0;
            o_bvalid    <= 1'b0;
            o_bresp     <= RESP_OKAY;
        end
        else
        begin
            if (i_awvalid && o_awready)
            begin
                aw_addr_reg <= i_awaddr;
                aw_got_reg  <= 1'b1;
                o_awready   <= 1'b0;
            end
            if (i_wvalid && o_wready)
            begin
                w_data_reg <= i_wdata;
                w_strb_reg <= i_wstrb;
                w_got_reg  <= 1'b1;
                o_wready   <= 1'b0;
            end
            if (do_write)
            begin
                o_bvalid <= 1'b1;
                if (hit(aw_addr_reg, IDX_PIN_CONFIG)
                    || hit(aw_addr_reg, IDX_SOFT_TRIGGER)
                    || hit(aw_addr_reg, IDX_LP_CONTROL)
                    || hit(aw_addr_reg, IDX_CAL_CONTROL)
                    || hit(aw_addr_reg, IDX_IRQ_CLEAR)
                    || hit(aw_addr_reg, IDX_IRQ_ENABLE))
                    o_bresp <= RESP_OKAY;
                else
                    o_bresp <= RESP_SLVERR;
            end
            else if (o_bvalid && i_bready)
            begin
                o_bvalid   <= 1'b0;
                aw_got_reg <= 1'b0;
                w_got_reg  <= 1'b0;
                o_awready  <= 1'b1;
                o_wready   <= 1'b1;
            end
        end
    end

    // Reserved bits are stored as written; software keeps them zero
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            pin_config_reg   <= RST_PIN_CONFIG;
            soft_trigger_reg <= RST_SOFT_TRIGGER; // [R4]
            lp_control_reg   <= RST_LP_CONTROL;   // [R13]
            cal_control_reg  <= RST_CAL_CONTROL;
            irq_enable_reg   <= RST_IRQ_ENABLE;
        end
        else if (do_write && w_strb_reg[0])
        begin
            if (hit(aw_addr_reg, IDX_PIN_CONFIG))
                pin_config_reg <= w_data_reg[7:0];
            else if (hit(aw_addr_reg, IDX_SOFT_TRIGGER))
                soft_trigger_reg <= w_data_reg[7:0];
            else if (hit(aw_addr_reg, IDX_LP_CONTROL))
                lp_control_reg <= w_data_reg[7:0];
            else if (hit(aw_addr_reg, IDX_CAL_CONTROL))
                cal_control_reg <= w_data_reg[7:0];
            else if (hit(aw_addr_reg, IDX_IRQ_ENABLE))
                irq_enable_reg <= w_data_reg[IRQ_W-1:0];
        end
    end

    assign irq_clear = (do_write && w_strb_reg[0]
                        && hit(aw_addr_reg, IDX_IRQ_CLEAR))
                       ? w_data_reg[IRQ_W-1:0] : '0;

    // ------------------------------------------------------------------
    // Read channel
    // ------------------------------------------------------------------
    always_comb
    begin
        rd_value = '0;
        rd_resp  = RESP_OKAY;
        if (hit(i_araddr, IDX_PIN_CONFIG))
            rd_value[7:0] = pin_config_reg;
        else if (hit(i_araddr, IDX_SOFT_TRIGGER))
            rd_value[7:0] = soft_trigger_reg;
        else if (hit(i_araddr, IDX_LP_CONTROL))
            rd_value[7:0] = lp_control_reg;
        else if (hit(i_araddr, IDX_CAL_CONTROL))
            rd_value[7:0] = cal_control_reg;
        else if (hit(i_araddr, IDX_CAL_STATUS))
            rd_value[7:0] = {1'b0, o_cal_trigger, o_core_sleep, state_reg,
                             i_flags}; // [R14] [R15]
        else if (hit(i_araddr, IDX_IRQ_STATUS))
            rd_value[IRQ_W-1:0] = irq_status_reg;
        else if (hit(i_araddr, IDX_IRQ_ENABLE))
            rd_value[IRQ_W-1:0] = irq_enable_reg;
        else if (!hit(i_araddr, IDX_IRQ_CLEAR))
            rd_resp = RESP_SLVERR;
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_arready <= 1'b1;
            o_rvalid  <= 1'b0;
            o_rdata   <= '0;
            o_rresp   <= RESP_OKAY;
        end
        else if (i_arvalid && o_arready)
        begin
            o_arready <= 1'b0;
            o_rvalid  <= 1'b1;
            o_rdata   <= rd_value;
            o_rresp   <= rd_resp;
        end
        else if (o_rvalid && i_rready)
        begin
            o_rvalid  <= 1'b0;
            o_arready <= 1'b1;
        end
    end

    // ------------------------------------------------------------------
    // Trigger selection and status pin
    // ------------------------------------------------------------------
    // Two stages: the pin has no relation to i_clk
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            trig_meta_reg <= 1'b0;
            trig_sync_reg <= 1'b0;
        end
        else
        begin
            trig_meta_reg <= i_external_trigger_pin; // [R17]
            trig_sync_reg <= trig_meta_reg;
        end
    end

    assign trig_sel = pin_config_reg[TRIG_SRC_BIT]
                      ? trig_sync_reg                      // [R3]
                      : soft_trigger_reg[SOFT_LEVEL_BIT];  // [R2] [R4]

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            o_cal_trigger    <= 1'b0;
            o_cal_status_pin <= 1'b0;
        end
        else
        begin
            o_cal_trigger <= trig_sel;
            case (pin_config_reg[STAT_SEL_MSB:STAT_SEL_LSB]) // [R1]
                SEL_FOREGROUND_DONE_FLAG:   o_cal_status_pin <= i_flags.foreground_done_flag;
                SEL_BG_HALTED: o_cal_status_pin <= i_flags.bg_halted;
                SEL_ALARM:     o_cal_status_pin <= i_flags.alarm;
                default:       o_cal_status_pin <= 1'b0;
            endcase
        end
    end

    // ------------------------------------------------------------------
    // Low-power sequencer
    // ------------------------------------------------------------------
    assign lp_active = cal_control_reg[BG_EN_BIT]
                       && lp_control_reg[LOW_POWER_CAL_ENABLE_BIT]; // [R13] [R16]
    assign trig_mode = lp_control_reg[TRIGGERED_SLEEP_MODE_BIT];

    ctlp_interval_timer #(.W(CNT_W)) u_timer
    (
        .i_clk   (i_clk),
        .i_rst_n (i_rst_n),
        .i_load  (tmr_load_reg),
        .i_count (tmr_count_reg),
        .o_done  (tmr_done)
    );

    // Triggered mode uses the selected trigger, unsynced soft bit included
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            state_reg     <= ST_IDLE;
            tmr_load_reg  <= 1'b0;
            tmr_count_reg <= '0;
            o_cal_start   <= 1'b0;
        end
        else
        begin
            tmr_load_reg <= 1'b0;
            o_cal_start  <= 1'b0;
            if (!lp_active)
                state_reg <= ST_IDLE; // [R16]
            else
                case (state_reg)
                    ST_IDLE, ST_CAL:
                        if (state_reg == ST_IDLE || i_core_cal_done)
                        begin
                            state_reg     <= ST_SLEEP;
                            tmr_load_reg  <= !trig_mode;
                            tmr_count_reg <= sleep_count(
                                lp_control_reg[SLEEP_MSB:SLEEP_LSB]); // [R7]
                        end
                    ST_SLEEP:
                        if (trig_mode ? !trig_sel : tmr_done) // [R11] [R12]
                        begin
                            state_reg     <= ST_SETTLE;
                            tmr_load_reg  <= 1'b1;
                            tmr_count_reg <= settle_count(
                                lp_control_reg[SETTLE_MSB:SETTLE_LSB]); // [R9]
                        end
                    ST_SETTLE:
                        if (tmr_done)
                        begin
                            state_reg   <= ST_CAL;
                            o_cal_start <= 1'b1; // [R9]
                        end
                    default:
                        state_reg <= ST_IDLE;
                endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            o_core_sleep <= 1'b0;
        else
            o_core_sleep <= lp_active && (state_reg == ST_SLEEP);
    end

    // ------------------------------------------------------------------
    // Interrupts
    // ------------------------------------------------------------------
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
            flags_prev_reg <= '0;
        else
            flags_prev_reg <= i_flags;
    end

    assign irq_event = {o_cal_start,
                        i_flags & ~flags_prev_reg};

    // Set wins over a clear in the same cycle
    always_ff @(posedge i_clk or negedge i_rst_n)
    begin
        if (!i_rst_n)
        begin
            irq_status_reg <= '0;
            o_irq          <= 1'b0;
        end
        else
        begin
            irq_status_reg <= (irq_status_reg & ~irq_clear) | irq_event;
            o_irq          <= |(irq_status_reg & irq_enable_reg);
        end
    end

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);

    sequence settle_ends;
        lp_active && state_reg == ST_SETTLE && tmr_done;
    endsequence

    sequence cal_begins;
        o_cal_start && state_reg == ST_CAL;
    endsequence

    AST_STATUS_PIN_ROUTE: assert property ( // [R1]
        ##1 o_cal_status_pin ==
            ($past(pin_config_reg[STAT_SEL_MSB:STAT_SEL_LSB]) == SEL_FOREGROUND_DONE_FLAG
                ? $past(i_flags.foreground_done_flag)
            : $past(pin_config_reg[STAT_SEL_MSB:STAT_SEL_LSB]) == SEL_BG_HALTED
                ? $past(i_flags.bg_halted)
            : $past(pin_config_reg[STAT_SEL_MSB:STAT_SEL_LSB]) == SEL_ALARM
                ? $past(i_flags.alarm) : 1'b0))
        else $error("status pin does not follow select");

    AST_SOFT_SOURCE: assert property ( // [R2]
        !pin_config_reg[TRIG_SRC_BIT]
        |=> o_cal_trigger == $past(soft_trigger_reg[SOFT_LEVEL_BIT]))
        else $error("software trigger not selected");

    AST_PIN_SOURCE: assert property ( // [R3]
        pin_config_reg[TRIG_SRC_BIT]
        |=> o_cal_trigger == $past(i_external_trigger_pin, 3))
        else $error("pin trigger not selected");

    AST_SETTLE_TO_CAL: assert property ( // [R9]
        settle_ends |=> cal_begins)
        else $error("calibration did not start after settle");

    AST_AUTO_SLEEP_HOLDS: assert property ( // [R11]
        lp_active && !trig_mode && state_reg == ST_SLEEP && !tmr_done
        |=> state_reg == ST_SLEEP)
        else $error("autonomous sleep ended early");

    AST_TRIG_SLEEP_HOLDS: assert property ( // [R12]
        lp_active && trig_mode && state_reg == ST_SLEEP && trig_sel
        |=> state_reg == ST_SLEEP || !lp_active)
        else $error("woke while trigger high");

    AST_TRIG_WAKE: assert property ( // [R12]
        lp_active && trig_mode && state_reg == ST_SLEEP && !trig_sel
        |=> state_reg == ST_SETTLE || !lp_active)
        else $error("did not wake on trigger low");

    AST_LP_GATED: assert property ( // [R13]
        !lp_active |=> state_reg == ST_IDLE ##1 !o_core_sleep)
        else $error("low-power active without both enables");

    AST_SLEEP_LOAD: assert property ( // [R7]
        lp_active && !trig_mode && state_reg == ST_IDLE
        |=> tmr_load_reg && tmr_count_reg ==
            sleep_count($past(lp_control_reg[SLEEP_MSB:SLEEP_LSB])))
        else $error("sleep interval loaded wrong");

endmodule // ctlp_cal_ctrl

/* ctlp_host_model.sv */
// Host controller model: drives the trigger pin, watches the status pin.
// Assumes the bench sets the wanted trigger level on i_level.
`timescale 1ns/1ps

module ctlp_host_model
(
    input  wire logic i_clk,
    input  wire logic i_level,
    input  wire logic i_cal_status_pin,
    output logic      o_external_trigger_pin,
    output logic      o_status_seen
);
    // Pin changes just after the edge, as a real host would
    always_ff @(posedge i_clk)
    begin
        o_external_trigger_pin <= i_level;
        o_status_seen          <= i_cal_status_pin;
    end
endmodule // ctlp_host_model

/* testbench.sv */
// Self-checking bench for the calibration controller.
// Assumes ctlp_pkg and ctlp_cal_ctrl are compiled first.
`timescale 1ns/1ps

module testbench;
    import ctlp_pkg::*;
    logic i_clk = 0, i_rst_n = 0, lvl = 1, b;
    logic [11:0] i_awaddr = 0, i_araddr = 0;
    logic [31:0] i_wdata = 0, rd, o_rdata;
    logic [3:0] i_wstrb = 4'hF;
    logic i_awvalid = 0, i_wvalid = 0, i_bready = 0, i_arvalid = 0;
    logic i_rready = 0, i_core_cal_done = 0, i_external_trigger_pin;
    logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_irq;
    logic o_cal_status_pin, o_cal_trigger, o_core_sleep, o_cal_start;
    logic [1:0] o_bresp, o_rresp, rs;
    logic seen;
    ctlp_flags_type i_flags = '0;
    int bad_count = 0, tests_run = 0, n, starts;

    initial forever #2.5 i_clk = ~i_clk;

    // Short intervals for the reset codes keep the run brief
    ctlp_cal_ctrl #(.SLEEP_CNT_4(41'd30), .SETTLE_CNT_1(41'd20)) dut (
        .i_clk, .i_rst_n, .i_awaddr, .i_awvalid, .o_awready, .i_wdata,
        .i_wstrb, .i_wvalid, .o_wready, .o_bresp, .o_bvalid, .i_bready,
        .i_araddr, .i_arvalid, .o_arready, .o_rdata, .o_rresp, .o_rvalid,
        .i_rready, .i_external_trigger_pin, .i_flags, .i_core_cal_done,
        .o_cal_status_pin, .o_cal_trigger, .o_core_sleep, .o_cal_start,
        .o_irq);
    ctlp_host_model host (.i_clk, .i_level(lvl),
        .i_cal_status_pin(o_cal_status_pin),
        .o_external_trigger_pin(i_external_trigger_pin),
        .o_status_seen(seen));

    // ------------------------------------------------------------------
    // Bus and check tasks
    // ------------------------------------------------------------------
    task results;
        if (bad_count == 0 && tests_run > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask
    task chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e)
        begin
            $display("BAD %0t %h %h", $time, g, e);
            bad_count++;
        end
    endtask
    task cyc(input int k);
        repeat (k)
        begin
            @(negedge i_clk);
            starts += o_cal_start;
        end
    endtask
    // Sampled mid-cycle so the handshake edge is known beforehand
    task w4(input int k);
        do
        begin
            @(negedge i_clk);
            b = k == 0 ? o_bvalid : k == 1 ? o_arready : o_rvalid;
            rd = o_rdata;
            rs = k == 0 ? o_bresp : o_rresp;
            @(posedge i_clk);
        end while (!b);
    endtask
    task wr(input logic [9:0] x, input logic [7:0] d);
        logic ta, tw;
        @(posedge i_clk);
        ta = 0;
        tw = 0;
        i_awaddr <= {x, 2'h0};
        i_wdata <= {24'h0, d};
        i_awvalid <= 1;
        i_wvalid <= 1;
        do
        begin
            @(negedge i_clk);
            ta |= o_awready;
            tw |= o_wready;
            @(posedge i_clk);
            if (ta) i_awvalid <= 0;
            if (tw) i_wvalid <= 0;
        end while (!(ta && tw));
        i_bready <= 1;
        w4(0);
        i_bready <= 0;
    endtask
    task rdr(input logic [9:0] x);
        @(posedge i_clk);
        i_araddr <= {x, 2'h0};
        i_arvalid <= 1;
        w4(1);
        i_arvalid <= 0;
        i_rready <= 1;
        w4(2);
        i_rready <= 0;
    endtask

    // ------------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------------
    initial
    begin
        repeat (6) @(posedge i_clk);
        i_rst_n <= 1;
        rdr(IDX_PIN_CONFIG); chk(rd, 32'h0);
        rdr(IDX_SOFT_TRIGGER); chk(rd, 32'h1);
        rdr(IDX_LP_CONTROL); chk(rd, 32'h88);
        rdr(10'h3FF); chk(32'(rs), 32'(RESP_SLVERR));
        wr(10'h3FF, 8'h00); chk(32'(rs), 32'(RESP_SLVERR));
        wr(IDX_SOFT_TRIGGER, 8'h00);
        cyc(6); chk(32'(o_cal_trigger), 0);
        wr(IDX_PIN_CONFIG, 8'h01);
        cyc(6); chk(32'(o_cal_trigger), 1);
        @(posedge i_clk) lvl <= 0;
        cyc(6); chk(32'(o_cal_trigger), 0);
        for (int c = 0; c < 4; c++)
        begin
            wr(IDX_PIN_CONFIG, 8'(c * 2));
            i_flags <= ctlp_flags_type'(3'(1 << c));
            cyc(4); chk(32'(seen), 32'(c < 3));
            @(posedge i_clk) i_flags <= ctlp_flags_type'(3'(~(1 << c)));
            cyc(4); chk(32'(seen), 0);
        end
        rdr(IDX_IRQ_STATUS); chk(rd, 32'h7);
        chk(32'(o_irq), 0);
        wr(IDX_IRQ_ENABLE, 8'h0F);
        cyc(3); chk(32'(o_irq), 1);
        wr(IDX_IRQ_CLEAR, 8'h0F);
        cyc(3); chk(32'(o_irq), 0);
        wr(IDX_SOFT_TRIGGER, 8'h01);
        wr(IDX_LP_CONTROL, 8'h89);
        starts = 0;
        cyc(100); chk(starts + o_core_sleep, 0);
        wr(IDX_CAL_CONTROL, 8'h01);
        n = 0;
        while (o_core_sleep !== 1'b1 && n < 50)
        begin
            cyc(1);
            n++;
        end
        chk(32'(o_core_sleep), 1);
        n = 0;
        starts = 0;
        while (starts == 0 && n < 200)
        begin
            cyc(1);
            n++;
        end
        chk(32'(n > 48 && n < 58), 1);
        @(posedge i_clk) i_core_cal_done <= 1;
        @(posedge i_clk) i_core_cal_done <= 0;
        lvl <= 1;
        wr(IDX_PIN_CONFIG, 8'h01);
        wr(IDX_LP_CONTROL, 8'h8B);
        starts = 0;
        cyc(100); chk(starts, 0);
        @(posedge i_clk) lvl <= 0;
        starts = 0;
        cyc(40); chk(starts, 1);
        wr(IDX_CAL_CONTROL, 8'h00);
        wr(IDX_PIN_CONFIG, 8'h00);
        results;
    end

    // Whole run is near 500 cycles; a hang ends well past that
    initial
    begin
        repeat (6000) @(posedge i_clk);
        bad_count++;
        results;
    end
endmodule // testbench
